// ### common/bgs_pkg.sv
// bgs_pkg: constants and types shared by the background-pin sync responder.
// assumes: one system clock; the serial clock exists only as a one-cycle tick.
`default_nettype none
package bgs_pkg;
  // ---------------------------------------------------------------
  // serial clock derivation
  // ---------------------------------------------------------------
  localparam int unsigned SER_DIV         = 8;
  localparam int unsigned SER_DIV_W       = 3;
  // ---------------------------------------------------------------
  // timing counts, in serial clock cycles
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_REQ_MIN    = 128;
  localparam int unsigned SYNC_DETECT     = 64;
  localparam int unsigned HOST_RELEASE    = 16;
  localparam int unsigned SYNC_RESP_LOW   = 128;
  localparam int unsigned SPEEDUP_LEN     = 1;
  localparam int unsigned SER_TIMEOUT     = 512;
  localparam int unsigned CNT_W           = 10;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        PIN_IDLE_RST    = 1'b1;
  // ---------------------------------------------------------------
  // responder states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BGS_IDLE      = 3'b000,
    BGS_WAIT_HIGH = 3'b001,
    BGS_DELAY     = 3'b010,
    BGS_DRIVE_LOW = 3'b011,
    BGS_SPEEDUP   = 3'b100
  } bgs_state_e;
endpackage : bgs_pkg
`default_nettype wire

// ### hdl/bgs_ser_div.sv
// bgs_ser_div: divides the vco-rate system clock into a serial clock tick.
// assumes: CLK_SYS is the vco clock; the tick is one system cycle wide.
`timescale 1ns/1ps
`default_nettype none
module bgs_ser_div
  import bgs_pkg::*;
#(
  parameter int unsigned DIV   = SER_DIV,
  parameter int unsigned DIV_W = SER_DIV_W
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // serial clock tick
  output var  logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } bgs_div_s;

  bgs_div_s st_ff;
  bgs_div_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == DIV_W'(DIV - 1)) begin  // [RULE_02]
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule : bgs_ser_div
`default_nettype wire

// ### hdl/bgs_sync_resp.sv
// bgs_sync_resp: detects a long-low sync request on the background pin,
// soft-resets the serial engine and answers with the timed reference pulse.
// assumes: pin input already synchronous to CLK_SYS; the serial engine reports
// an unfinished transfer on XFER_BUSY and a waiting acknowledge on ACK_PENDING.
//
// Summary of operation
// [RULE_01] host holds the pin low at least 128 slowest serial cycles to request sync
// [RULE_02] serial clock is the vco clock divided by eight
// [RULE_03] host ends its request with a short driven-high speedup pulse
// [RULE_04] host then releases the pin and listens for the response
// [RULE_05] on a sync request, discard any partial command or bit, like a time-out
// [RULE_06] wait for the pin to return high before responding
// [RULE_07] then wait 16 serial cycles for the host speedup to end
// [RULE_08] drive the pin low for exactly 128 serial cycles
// [RULE_09] drive high one serial cycle, then release the pin
// [RULE_10] host times the low response to set its bit rate
// [RULE_11] after the response, next falling edge starts a command or sync request
// [RULE_12] a sync request cancels a pending acknowledge and is handled normally
// [RULE_13] a command not correctly received gets no acknowledge pulse
// [RULE_14] over 512 serial cycles between falling edges mid-transfer forces soft reset
// [RULE_15] a low longer than any valid bit time counts as a sync request
`timescale 1ns/1ps
`default_nettype none
module bgs_sync_resp
  import bgs_pkg::*;
#(
  parameter int unsigned DETECT_CYC  = SYNC_DETECT,
  parameter int unsigned RELEASE_CYC = HOST_RELEASE,
  parameter int unsigned RESP_CYC    = SYNC_RESP_LOW,
  parameter int unsigned TOUT_CYC    = SER_TIMEOUT
) (
  // clock, reset, enable
  input  wire logic CLK_SYS,
  input  wire logic RESET_N,
  input  wire logic CLK_EN,
  // background pin
  input  wire logic BACKGROUND_PIN_PIN_IN,
  output var  logic BACKGROUND_PIN_PIN_OUT,
  output var  logic BACKGROUND_PIN_PIN_OE,
  // serial engine status
  input  wire logic XFER_BUSY,
  input  wire logic ACK_PENDING,
  // serial engine control
  output var  logic SOFT_RESET,
  output var  logic ACK_CANCEL,
  output var  logic ACK_INHIBIT,
  output var  logic FRAME_START,
  output var  logic SYNC_ACTIVE
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    bgs_state_e       state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] tout_cnt;
    logic             pin_prev;
    logic             pin_out;
    logic             pin_oe;
    logic             soft_rst;
    logic             ack_cancel;
    logic             ack_inhibit;
    logic             frame_start;
    logic             sync_active;
  } bgs_resp_s;

  bgs_resp_s st_ff;
  bgs_resp_s nxt_st;
  logic      ser_tick;
  logic      fall;
  logic      sync_seen;
  logic      tout_hit;

  // ---------------------------------------------------------------
  // serial clock
  // ---------------------------------------------------------------
  bgs_ser_div #(
    .DIV   (SER_DIV),
    .DIV_W (SER_DIV_W)
  ) u_div (
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .clk_en  (CLK_EN),
    .tick    (ser_tick)
  );

  assign fall = st_ff.pin_prev & ~BACKGROUND_PIN_PIN_IN;

  // a valid bit lasts at most a few tens of serial cycles, so a low
  // reaching the threshold can only be a sync request; the threshold sits
  // well below the host minimum to tolerate a slower-running host clock
  assign sync_seen = (st_ff.state == BGS_IDLE) && !BACKGROUND_PIN_PIN_IN && ser_tick
                     && (st_ff.low_cnt == CNT_W'(DETECT_CYC - 1));  // [RULE_15] [RULE_01]

  assign tout_hit = (st_ff.state == BGS_IDLE) && XFER_BUSY && ser_tick
                    && (st_ff.tout_cnt == CNT_W'(TOUT_CYC));  // [RULE_14]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.pin_prev    = BACKGROUND_PIN_PIN_IN;
    nxt_st.soft_rst    = 1'b0;
    nxt_st.ack_cancel  = 1'b0;
    nxt_st.frame_start = 1'b0;

    // low-time measurement runs only while the responder is idle
    if (st_ff.state != BGS_IDLE || BACKGROUND_PIN_PIN_IN) begin
      nxt_st.low_cnt = '0;
    end else if (ser_tick && st_ff.low_cnt != CNT_W'(DETECT_CYC)) begin
      nxt_st.low_cnt = st_ff.low_cnt + 1'b1;
    end

    // gap between falling edges, watched only mid-transfer
    if (fall || !XFER_BUSY || st_ff.state != BGS_IDLE) begin
      nxt_st.tout_cnt = '0;
    end else if (ser_tick && st_ff.tout_cnt < CNT_W'(TOUT_CYC)) begin
      nxt_st.tout_cnt = st_ff.tout_cnt + 1'b1;
    end

    case (st_ff.state)
      BGS_IDLE: begin
        nxt_st.pin_oe  = 1'b0;
        nxt_st.pin_out = 1'b1;
        if (fall) begin
          nxt_st.frame_start = 1'b1;  // [RULE_11]
          nxt_st.ack_inhibit = 1'b0;
        end
        if (sync_seen) begin
          nxt_st.state       = BGS_WAIT_HIGH;
          nxt_st.soft_rst    = 1'b1;  // [RULE_05]
          nxt_st.ack_cancel  = ACK_PENDING;  // [RULE_12]
          nxt_st.ack_inhibit = 1'b1;  // [RULE_13]
          nxt_st.sync_active = 1'b1;
        end else if (tout_hit) begin
          // park past the limit: one stall gives one soft reset, not one per tick
          nxt_st.tout_cnt    = CNT_W'(TOUT_CYC + 1);  // [RULE_14]
          nxt_st.soft_rst    = 1'b1;  // [RULE_14]
          nxt_st.ack_inhibit = 1'b1;  // [RULE_13]
        end
      end
      BGS_WAIT_HIGH: begin
        // host may still be holding the pin low; its speedup falls in the delay that follows
        if (BACKGROUND_PIN_PIN_IN) begin  // [RULE_06]
          nxt_st.state = BGS_DELAY;
          nxt_st.cnt   = '0;
        end
      end
      BGS_DELAY: begin
        if (ser_tick) begin
          if (st_ff.cnt == CNT_W'(RELEASE_CYC - 1)) begin  // [RULE_07]
            nxt_st.state   = BGS_DRIVE_LOW;
            nxt_st.cnt     = '0;
            nxt_st.pin_out = 1'b0;
            nxt_st.pin_oe  = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
          end
        end
      end
      BGS_DRIVE_LOW: begin
        if (ser_tick) begin
          if (st_ff.cnt == CNT_W'(RESP_CYC - 1)) begin  // [RULE_08]
            nxt_st.state   = BGS_SPEEDUP;
            nxt_st.cnt     = '0;
            nxt_st.pin_out = 1'b1;  // [RULE_09]
          end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
          end
        end
      end
      BGS_SPEEDUP: begin
        if (ser_tick && st_ff.cnt == CNT_W'(SPEEDUP_LEN - 1)) begin
          nxt_st.state       = BGS_IDLE;
          nxt_st.pin_oe      = 1'b0;  // [RULE_09]
          nxt_st.sync_active = 1'b0;
          nxt_st.cnt         = '0;
        end else if (ser_tick) begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      default: begin
        nxt_st.state  = BGS_IDLE;
        nxt_st.pin_oe = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      st_ff          <= '0;
      st_ff.state    <= BGS_IDLE;
      st_ff.pin_prev <= PIN_IDLE_RST;
      st_ff.pin_out  <= PIN_IDLE_RST;
    end else if (CLK_EN) begin
      st_ff <= nxt_st;
    end
  end

  assign BACKGROUND_PIN_PIN_OUT = st_ff.pin_out;
  assign BACKGROUND_PIN_PIN_OE  = st_ff.pin_oe;
  assign SOFT_RESET   = st_ff.soft_rst;
  assign ACK_CANCEL   = st_ff.ack_cancel;
  assign ACK_INHIBIT  = st_ff.ack_inhibit;
  assign FRAME_START  = st_ff.frame_start;
  assign SYNC_ACTIVE  = st_ff.sync_active;
endmodule : bgs_sync_resp
`default_nettype wire

// ### bench/bgs_sync_checker.sv
// bgs_sync_checker: pin timing and control pulse checks for bgs_sync_resp
// assumes: CLK_EN held high during a sync response, so one serial tick is SER_DIV clocks
`timescale 1ns/1ps
`default_nettype none
module bgs_sync_checker
  import bgs_pkg::*;
#(parameter int unsigned RESP_CYC = SYNC_RESP_LOW) (
  // clock and pin
  input wire logic CLK_SYS, RESET_N, CLK_EN, BACKGROUND_PIN_PIN_IN, BACKGROUND_PIN_PIN_OUT, BACKGROUND_PIN_PIN_OE,
  // serial engine
  input wire logic XFER_BUSY, ACK_PENDING, SOFT_RESET, ACK_CANCEL,
  input wire logic ACK_INHIBIT, FRAME_START, SYNC_ACTIVE
);
  logic [15:0] low_cnt_ff;
  always_ff @(posedge CLK_SYS)
    low_cnt_ff <= (RESET_N && BACKGROUND_PIN_PIN_OE && !BACKGROUND_PIN_PIN_OUT) ? low_cnt_ff + 16'(CLK_EN) : 16'h0;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  sequence speedup_s; BACKGROUND_PIN_PIN_OE [*8] ##1 !BACKGROUND_PIN_PIN_OE; endsequence
  resp_len_a: assert property ($rose(BACKGROUND_PIN_PIN_OUT) |-> low_cnt_ff == 16'(RESP_CYC * SER_DIV))
    else $error("response low length wrong");
  speedup_len_a: assert property ($rose(BACKGROUND_PIN_PIN_OUT) |-> speedup_s)
    else $error("speedup pulse length wrong");
  wait_high_a: assert property ($rose(BACKGROUND_PIN_PIN_OE) |-> !BACKGROUND_PIN_PIN_OUT && $past(BACKGROUND_PIN_PIN_IN, 8))
    else $error("drive began too soon");
  drive_in_sync_a: assert property (BACKGROUND_PIN_PIN_OE |-> SYNC_ACTIVE)
    else $error("pin driven outside sync");
  sync_reset_a: assert property ($rose(SYNC_ACTIVE) |-> SOFT_RESET ##1 !SOFT_RESET)
    else $error("sync without soft reset pulse");
  cancel_need_a: assert property ($rose(SYNC_ACTIVE) && $past(ACK_PENDING) |-> ACK_CANCEL)
    else $error("pending acknowledge not cancelled");
  cancel_why_a: assert property (ACK_CANCEL |-> $rose(SYNC_ACTIVE))
    else $error("stray acknowledge cancel");
  frame_edge_a: assert property ($fell(BACKGROUND_PIN_PIN_IN) && !SYNC_ACTIVE |-> ##[1:2] FRAME_START)
    else $error("falling edge gave no frame start");
  inhibit_set_a: assert property (SOFT_RESET |-> ##[0:1] ACK_INHIBIT)
    else $error("acknowledge not inhibited");
  enable_freeze_a: assert property (!CLK_EN |=> $stable({BACKGROUND_PIN_PIN_OE, BACKGROUND_PIN_PIN_OUT, SOFT_RESET, SYNC_ACTIVE, FRAME_START, ACK_INHIBIT, ACK_CANCEL}))
    else $error("outputs moved while clock enable low");
endmodule : bgs_sync_checker
bind bgs_sync_resp bgs_sync_checker #(.RESP_CYC(RESP_CYC)) bgs_sync_checker_inst (.*);
`default_nettype wire

// ### bench/bgs_host_model.sv
// bgs_host_model: debug host on the background pin, pin has a pull-up
// assumes: host drives on the falling edge; request length in serial ticks, response length in system clocks
`timescale 1ns/1ps
`default_nettype none
module bgs_host_model (
  input  wire logic        clk,
  input  wire logic        dut_oe,
  input  wire logic        dut_out,
  output var  logic        pin,
  output var  logic        resp_done,
  output var  logic [15:0] resp_len
);
  logic host_oe = 1'b0;
  logic host_out = 1'b1;
  // released pin floats up to the pull-up level
  assign pin = dut_oe ? dut_out : (host_oe ? host_out : 1'b1);
  initial begin
    resp_done = 1'b0;
    resp_len = 16'h0;
  end
  task automatic sync_req(input int ticks, input bit listen);
    int n;
    @(negedge clk) {host_oe, host_out} = 2'b10;
    repeat (ticks * 8) @(negedge clk);
    host_out = 1'b1;
    @(negedge clk) host_oe = 1'b0;
    if (listen) begin
      for (n = 0; n < 400 && pin; n++) @(negedge clk);
      for (n = 0; n < 4000 && !pin; n++) @(negedge clk);
      resp_len = 16'(n);
      repeat (16) @(negedge clk);
      resp_done = 1'b1;
      @(negedge clk) resp_done = 1'b0;
    end
  endtask : sync_req
endmodule : bgs_host_model
`default_nettype wire

// ### bench/bgs_sync_resp_tb_top.sv
// bgs_sync_resp_tb_top: self-checking bench for the sync responder
// assumes: shrunk counts 4/2/8/16 ticks; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module bgs_sync_resp_tb_top;
  import bgs_pkg::*;
  localparam int unsigned RESP = 8;
  logic clk = 1'b0, reset_n = 1'b0, xfer_busy = 1'b0, ack_pending = 1'b0, clk_en = 1'b1;
  logic pin, oe, out, soft_rst, ack_cancel, frame_start, sync_act, resp_done, ack_inh;
  logic [15:0] resp_len;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  initial forever #2.5 clk = ~clk;
  bgs_sync_resp #(.DETECT_CYC(4), .RELEASE_CYC(2), .RESP_CYC(RESP), .TOUT_CYC(16))
    bgs_sync_resp_inst (.CLK_SYS(clk), .RESET_N(reset_n), .CLK_EN(clk_en),
    .BACKGROUND_PIN_PIN_IN(pin), .BACKGROUND_PIN_PIN_OUT(out), .BACKGROUND_PIN_PIN_OE(oe), .XFER_BUSY(xfer_busy),
    .ACK_PENDING(ack_pending), .SOFT_RESET(soft_rst), .ACK_CANCEL(ack_cancel),
    .ACK_INHIBIT(ack_inh), .FRAME_START(frame_start), .SYNC_ACTIVE(sync_act));
  bgs_host_model bgs_host_model_inst (.clk(clk), .dut_oe(oe), .dut_out(out), .pin(pin),
    .resp_done(resp_done), .resp_len(resp_len));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic pop_check(input string what, input logic [15:0] seen);
    check(what, seen, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFFF);
  endtask : pop_check
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // monitor: each result takes the oldest note
  // ----------------------------------------
  always @(posedge clk) if (reset_n) begin
    if (frame_start === 1'b1) pop_check("frame start", {15'h7800, ack_inh});
    if (soft_rst === 1'b1) pop_check("soft reset", {13'h0, ack_inh, ack_cancel, sync_act});
    if (resp_done === 1'b1) pop_check("response low", resp_len);
  end
  initial begin
    int t;
    t = $urandom(32'h6857D207);
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    for (int ack = 0; ack < 2; ack++) begin
      t = 5 + $urandom_range(7);
      ack_pending = ack[0];
      exp_q.push_back(16'hF000);
      exp_q.push_back(16'h5 + 16'(ack * 2));
      exp_q.push_back(16'(RESP * SER_DIV));
      bgs_host_model_inst.sync_req(t, 1'b1);
      ack_pending = 1'b0;
      $display("test sync ack %0d done", ack);
    end
    // short low is a bit, not a sync request
    exp_q.push_back(16'hF000);
    bgs_host_model_inst.sync_req(2, 1'b0);
    repeat (60) @(negedge clk);
    $display("test short low done");
    // stalled transfer: exactly one soft reset, pin untouched
    // a frozen enable mid-stall must not count toward the time-out
    xfer_busy = 1'b1;
    exp_q.push_back(16'h4);
    repeat (40) @(negedge clk);
    clk_en = 1'b0;
    repeat (50) @(negedge clk);
    clk_en = 1'b1;
    repeat (8 * 24) @(negedge clk);
    xfer_busy = 1'b0;
    repeat (20) @(negedge clk);
    $display("test time-out done");
    check("notes left", 16'(exp_q.size()), 16'h0);
    final_report();
  end
endmodule : bgs_sync_resp_tb_top
`default_nettype wire
